/* src/cgr_regs.sv */
`timescale 1ns/1ns
// Notes on behaviour
// RULE1: Output zero enable follows bit 7, resets one
// RULE2: Strap pins captured at power-up, read back
// RULE3: Host writes zero to test bit five
// RULE4: Bit 4 enables spread, powers up set
// RULE5: Bits 7:5 pick spread profile, default 011
// RULE6: Bits 4:0 pick aligner rate, zero off
// RULE7: Aligner frequency never carries spread modulation
// RULE8: Mode bit picks strap table or aligner
// RULE9: Writes need unlock, taking effect next block; the unlock bit at offset 0 is written even while locked
// RULE10: Writes to strap bits are ignored
module cgr_regs
    import cgr_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Serial management pins
    input wire logic sclk,
    input wire logic sdata_in,
    output logic sdata_out,
    output logic sdata_oe,
    // Strap pins
    input wire logic floppy_clock_select_pin,
    input wire logic [3:0] freq_select_pin,
    // Link clock source mode from the control byte
    input wire logic aligner_mode,
    // Clock control outputs
    output logic bus_link_clock_out0_enable,
    output logic spread_active,
    output logic [2:0] spread_profile,
    output logic link_clock_rate_aligner,
    output logic [4:0] link_clock_rate_code,
    output logic link_clock_66_off,
    output logic floppy_clock_select_latch,
    output logic [3:0] freq_select
);
    cgr_smb_if smb ();

    cgr_state_t state_ff, nxt_state;
    logic [7:0] ptr_ff, nxt_ptr;
    logic [7:0] cnt_ff, nxt_cnt;
    logic ack_ff, nxt_ack;
    logic we_ff, we_active_ff;
    logic out0_ff, test_ff, spread_enable_ff;
    logic [7:0] spread_ff;
    logic [3:0] fs_ff;
    logic floppy_ff;
    logic captured_ff;

    cgr_smb_engine u_engine (
        .clk(clk),
        .rst(rst),
        .sclk(sclk),
        .sdata_in(sdata_in),
        .sdata_out(sdata_out),
        .sdata_oe(sdata_oe),
        .bus(smb)
    );

    // ************************************************************
    // Register read and write decode
    // ************************************************************
    wire [7:0] rx = smb.rx_byte;
    wire addr_hit = (rx[7:1] == DEV_ADDR);
    wire wr_slot = smb.byte_done && state_ff == ST_WDATA && cnt_ff != 8'h00;
    wire wr_open = wr_slot && we_active_ff; // RULE9
    wire wr_we = wr_slot && ptr_ff == REG_WE_OFS;
    wire wr_latch = wr_open && ptr_ff == REG_LATCH_OFS;
    wire wr_spread = wr_open && ptr_ff == REG_SPREAD_OFS;
    wire take_cmd = smb.byte_done && state_ff == ST_CMD;
    wire [7:0] latch_byte = {out0_ff, floppy_ff, test_ff, spread_enable_ff,
                             fs_ff};
    wire [7:0] rd_byte = (ptr_ff == REG_WE_OFS) ? {7'h00, we_ff} :
                         (ptr_ff == REG_LATCH_OFS) ? latch_byte :
                         (ptr_ff == REG_SPREAD_OFS) ? spread_ff : 8'h00;

    // Byte engine steering
    assign smb.ack = ack_ff;
    assign smb.tx_mode = (state_ff == ST_RCNT) || (state_ff == ST_RDATA);
    assign smb.tx_byte = (state_ff == ST_RCNT) ? RD_COUNT : rd_byte;

    // ************************************************************
    // Block protocol state machine
    // ************************************************************
    always_comb begin
        nxt_state = state_ff;
        nxt_ptr = ptr_ff;
        nxt_cnt = cnt_ff;
        nxt_ack = ack_ff;
        if (smb.stop) begin
            nxt_state = ST_IDLE;
        end else if (smb.start) begin
            // No stale acknowledge while parked after a start
            nxt_ack = 1'b0;
            nxt_state = ST_ADDR;
        end else if (smb.nack) begin
            nxt_state = ST_SKIP;
        end else if (smb.byte_done) begin
            case (state_ff)
                ST_ADDR: begin
                    nxt_ack = addr_hit;
                    nxt_state = !addr_hit ? ST_SKIP :
                                rx[0] ? ST_RCNT : ST_CMD;
                end
                ST_CMD: begin
                    nxt_ptr = rx;
                    nxt_ack = 1'b1;
                    nxt_state = ST_CNT;
                end
                ST_CNT: begin
                    nxt_cnt = rx;
                    nxt_ack = 1'b1;
                    nxt_state = ST_WDATA;
                end
                ST_WDATA: begin
                    // Locked blocks still complete, data is dropped except the unlock byte at REG_WE_OFS
                    nxt_ack = 1'b1;
                    if (cnt_ff != 8'h00) begin
                        nxt_ptr = ptr_ff + 8'h01;
                        nxt_cnt = cnt_ff - 8'h01;
                    end
                end
                ST_RCNT: begin
                    nxt_ack = 1'b0;
                    nxt_state = ST_RDATA;
                end
                ST_RDATA: begin
                    nxt_ack = 1'b0;
                    nxt_ptr = ptr_ff + 8'h01;
                end
                default: begin
                    nxt_ack = 1'b0;
                end
            endcase
        end
    end

    // State registers
    always_ff @(posedge clk) begin
        state_ff <= rst ? ST_IDLE : nxt_state;
        ptr_ff <= rst ? 8'h00 : nxt_ptr;
        cnt_ff <= rst ? 8'h00 : nxt_cnt;
        ack_ff <= rst ? 1'b0 : nxt_ack;
    end

    // Unlock bit, sampled at each block command
    always_ff @(posedge clk) begin
        if (rst) begin
            we_ff <= WE_RST;
            we_active_ff <= WE_RST;
        end else begin
            if (wr_we) begin
                we_ff <= rx[WE_BIT];
            end
            if (take_cmd) begin
                we_active_ff <= we_ff; // RULE9
            end
        end
    end

    // ************************************************************
    // Configuration registers
    // ************************************************************
    always_ff @(posedge clk) begin
        if (rst) begin
            out0_ff <= OUT0_RST; // RULE1
            test_ff <= TEST_RST; // RULE3
            spread_enable_ff <= SPREAD_ENABLE_RST; // RULE4
            spread_ff <= SPREAD_RST; // RULE5 RULE6
        end else begin
            if (wr_latch) begin
                // Strap bits 6 and 3:0 are not writable
                out0_ff <= rx[LB_OUT0]; // RULE1 RULE10
                test_ff <= rx[LB_TEST];
                spread_enable_ff <= rx[LB_SPREAD_ENABLE]; // RULE4
            end
            if (wr_spread) begin
                spread_ff <= rx;
            end
        end
    end

    // Strap capture in the first cycle after reset release
    always_ff @(posedge clk) begin
        if (rst) begin
            captured_ff <= 1'b0;
            fs_ff <= 4'h0;
            floppy_ff <= 1'b0;
        end else if (!captured_ff) begin
            captured_ff <= 1'b1;
            fs_ff <= freq_select_pin; // RULE2
            floppy_ff <= floppy_clock_select_pin; // RULE2
        end
    end

    // ************************************************************
    // Clock control outputs
    // ************************************************************
    wire code_is_off = (spread_ff[SP_CODE_HI:0] == ALIGN_OFF);
    assign bus_link_clock_out0_enable = out0_ff; // RULE1
    assign spread_active = spread_enable_ff & ~aligner_mode; // RULE4 RULE7
    assign spread_profile = spread_ff[SP_PROF_HI:SP_PROF_LO]; // RULE5
    assign link_clock_rate_aligner = aligner_mode; // RULE8
    assign link_clock_rate_code = aligner_mode ? spread_ff[SP_CODE_HI:0]
                                               : {1'b0, fs_ff}; // RULE8
    assign link_clock_66_off = aligner_mode & code_is_off; // RULE6
    assign floppy_clock_select_latch = floppy_ff;
    assign freq_select = fs_ff;

    // ************************************************************
    // Assertions
    // ************************************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    a_out0_write_follow: assert property ( // RULE1
        wr_latch |=> bus_link_clock_out0_enable == $past(rx[LB_OUT0]))
        else $error("output zero enable did not follow write");
    a_out0_reset_one: assert property ( // RULE1
        $past(rst) |-> bus_link_clock_out0_enable && spread_enable_ff)
        else $error("enable bits not set after reset");
    a_strap_capture: assert property ( // RULE2
        $rose(captured_ff) |-> freq_select == $past(freq_select_pin)
            && floppy_clock_select_latch == $past(floppy_clock_select_pin))
        else $error("strap pins not captured");
    a_spread_gate: assert property ( // RULE4
        spread_active == (latch_byte[LB_SPREAD_ENABLE] && !aligner_mode))
        else $error("spread output disagrees with enable");
    a_profile_reset: assert property ( // RULE5
        $past(rst) |-> spread_profile == PROF_RST
            && link_clock_rate_code[3:0] == 4'h0)
        else $error("spread profile reset value wrong");
    a_aligner_off: assert property ( // RULE6
        link_clock_66_off == (link_clock_rate_aligner
            && link_clock_rate_code == ALIGN_OFF))
        else $error("aligner output off flag disagrees with code");
    a_aligner_no_spread: assert property ( // RULE7
        aligner_mode |-> !spread_active)
        else $error("spread applied to aligner frequency");
    a_link_source: assert property ( // RULE8
        !aligner_mode |-> link_clock_rate_code == {1'b0, freq_select})
        else $error("link rate not from strap table");
    a_locked_write: assert property ( // RULE9
        (wr_slot && !we_active_ff) |=> $stable(spread_ff)
            && $stable(bus_link_clock_out0_enable))
        else $error("write took effect while locked");
    a_strap_readonly: assert property ( // RULE10
        (captured_ff && wr_latch) |=> $stable(freq_select)
            && $stable(floppy_clock_select_latch))
        else $error("strap bits changed by write");

    c_unlocked_write: cover property (wr_spread);
    c_block_read: cover property (state_ff == ST_RDATA && smb.byte_done);
    c_locked_drop: cover property (wr_slot && !we_active_ff);
    c_aligner_use: cover property (aligner_mode && !link_clock_66_off);
    c_aligner_off: cover property (link_clock_66_off);
endmodule

/* src/cgr_pkg.sv */
package cgr_pkg;

    // ************************************************************
    // Register offsets (command codes)
    // ************************************************************
    localparam logic [7:0] REG_WE_OFS = 8'h00;
    localparam logic [7:0] REG_LATCH_OFS = 8'h04;
    localparam logic [7:0] REG_SPREAD_OFS = 8'h05;

    // ************************************************************
    // Field positions
    // ************************************************************
    localparam int WE_BIT = 0;
    localparam int LB_OUT0 = 7;
    localparam int LB_FLOPPY = 6;
    localparam int LB_TEST = 5;
    localparam int LB_SPREAD_ENABLE = 4;
    localparam int SP_PROF_HI = 7;
    localparam int SP_PROF_LO = 5;
    localparam int SP_CODE_HI = 4;

    // ************************************************************
    // Reset values
    // ************************************************************
    localparam logic WE_RST = 1'b0;
    localparam logic OUT0_RST = 1'b1;
    localparam logic TEST_RST = 1'b0;
    localparam logic SPREAD_ENABLE_RST = 1'b1;
    localparam logic [7:0] SPREAD_RST = 8'h60;
    localparam logic [2:0] PROF_RST = 3'h3;
    localparam logic [4:0] ALIGN_OFF = 5'h00;

    // ************************************************************
    // Serial bus constants
    // ************************************************************
    localparam logic [6:0] DEV_ADDR = 7'h69;
    localparam logic [7:0] RD_COUNT = 8'h06;
    localparam logic [3:0] ACK_SLOT = 4'h8;
    localparam logic [3:0] LAST_BIT = 4'h7;

    // Byte-level protocol states, Gray along the usual path
    typedef enum logic [2:0] {
        ST_IDLE  = 3'b000,
        ST_ADDR  = 3'b001,
        ST_CMD   = 3'b011,
        ST_CNT   = 3'b010,
        ST_WDATA = 3'b110,
        ST_RCNT  = 3'b111,
        ST_RDATA = 3'b101,
        ST_SKIP  = 3'b100
    } cgr_state_t;

endpackage

/* src/cgr_smb_if.sv */
`timescale 1ns/1ns
interface cgr_smb_if;
    logic start;
    logic stop;
    logic byte_done;
    logic nack;
    logic [7:0] rx_byte;
    logic ack;
    logic tx_mode;
    logic [7:0] tx_byte;

    modport engine (
        output start, stop, byte_done, nack, rx_byte,
        input ack, tx_mode, tx_byte
    );
    modport regs (
        input start, stop, byte_done, nack, rx_byte,
        output ack, tx_mode, tx_byte
    );
endinterface

/* src/cgr_smb_engine.sv */
`timescale 1ns/1ns
module cgr_smb_engine
    import cgr_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Serial pins
    input wire logic sclk,
    input wire logic sdata_in,
    output logic sdata_out,
    output logic sdata_oe,
    // Byte side
    cgr_smb_if.engine bus
);
    logic scl_ff;
    logic sda_ff;
    logic active_ff;
    logic [3:0] bit_ff;
    logic [7:0] sh_ff;
    logic done_ff;

    // ************************************************************
    // Line events
    // ************************************************************
    wire scl_rise = sclk & ~scl_ff;
    wire scl_fall = ~sclk & scl_ff;
    wire in_ack = (bit_ff == ACK_SLOT);
    wire take_bit = scl_rise & active_ff & ~in_ack;
    assign bus.start = sclk & scl_ff & sda_ff & ~sdata_in;
    assign bus.stop = sclk & scl_ff & ~sda_ff & sdata_in;
    assign bus.nack = scl_rise & active_ff & in_ack & bus.tx_mode & sdata_in;
    assign bus.byte_done = done_ff;
    assign bus.rx_byte = sh_ff;

    // Open drain: only ever pulls low
    assign sdata_out = 1'b0;
    assign sdata_oe = active_ff & (in_ack ? bus.ack
                                          : (bus.tx_mode & ~sh_ff[7]));

    // Pin history
    always_ff @(posedge clk) begin
        scl_ff <= rst ? 1'b1 : sclk;
        sda_ff <= rst ? 1'b1 : sdata_in;
        done_ff <= ~rst & take_bit & (bit_ff == LAST_BIT);
    end

    // Frame tracking
    always_ff @(posedge clk) begin
        if (rst || bus.stop) begin
            active_ff <= 1'b0;
        end else if (bus.start) begin
            active_ff <= 1'b1;
        end
    end

    // Bit counter and shifter, data changes on falling clock
    always_ff @(posedge clk) begin
        if (rst) begin
            bit_ff <= 4'h0;
            sh_ff <= 8'h00;
        end else if (bus.start) begin
            // Park in the ack slot so the next clock fall opens bit 0
            bit_ff <= ACK_SLOT;
            sh_ff <= 8'h00;
        end else if (take_bit && !bus.tx_mode) begin
            sh_ff <= {sh_ff[6:0], sdata_in};
        end else if (scl_fall && active_ff) begin
            bit_ff <= in_ack ? 4'h0 : bit_ff + 4'h1;
            if (bus.tx_mode) begin
                sh_ff <= in_ack ? bus.tx_byte : {sh_ff[6:0], 1'b1};
            end
        end
    end
endmodule

/* testbench/cgr_host_model.sv */
`timescale 1ns/1ns
// ************************************************************
// Serial management host driving the configuration bytes
// ************************************************************
module cgr_host_model (
    // Clock
    input wire logic clk,
    // Serial pins, data line pulled up
    output logic sclk,
    output logic host_oe,
    input wire logic sdata,
    // Read results
    output logic [7:0] got,
    output logic got_v,
    output int nack_cnt
);
    // Idle bus, both lines released
    initial begin
        sclk = 1'b1;
        host_oe = 1'b0;
        got = 8'h00;
        got_v = 1'b0;
        nack_cnt = 0;
    end

    task automatic wt(input int n);
        repeat (n) @(posedge clk);
    endtask

    // Data changes mid low phase, sampled late in high phase
    task automatic bit_io(input logic b, output logic r);
        sclk <= 1'b0;
        wt(2);
        host_oe <= !b;
        wt(4);
        sclk <= 1'b1;
        wt(4);
        r = sdata;
    endtask

    // Start, or repeated start after an acknowledge slot
    task automatic start();
        sclk <= 1'b0;
        wt(2);
        host_oe <= 1'b0;
        wt(4);
        sclk <= 1'b1;
        wt(4);
        host_oe <= 1'b1;
        wt(4);
    endtask

    task automatic stop();
        sclk <= 1'b0;
        wt(2);
        host_oe <= 1'b1;
        wt(4);
        sclk <= 1'b1;
        wt(4);
        host_oe <= 1'b0;
        wt(4);
    endtask

    // Byte out, then the device's acknowledge is checked
    task automatic wbyte(input logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(d[i], r);
        end
        bit_io(1'b1, r);
        if (r) begin
            nack_cnt++;
        end
    endtask

    // Byte in, host answers with ack or, on the last byte, nack
    task automatic rbyte(input logic last);
        logic [7:0] v;
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(1'b1, v[i]);
        end
        bit_io(last, r);
        got <= v;
        got_v <= 1'b1;
        @(posedge clk);
        got_v <= 1'b0;
    endtask

    // Block write: address, start offset, count, data
    task automatic wr_block(input logic [7:0] c, input logic [7:0] d[$]);
        start();
        wbyte(8'hd2);
        wbyte(c);
        wbyte(8'(d.size()));
        foreach (d[i]) begin
            wbyte(d[i]);
        end
        stop();
    endtask

    // Block read: count byte first, then n data bytes
    task automatic rd_block(input logic [7:0] c, input int n);
        start();
        wbyte(8'hd2);
        wbyte(c);
        start();
        wbyte(8'hd3);
        rbyte(1'b0);
        for (int i = 0; i < n; i++) begin
            rbyte(i == n - 1);
        end
        stop();
    endtask
endmodule

/* testbench/clock_gen_latch_spread_regs_bench.sv */
`timescale 1ns/1ns
module clock_gen_latch_spread_regs_bench;
    import cgr_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic am = 1'b0;
    logic fl = 1'b0;
    logic [3:0] fs = 4'h0;
    logic cfl, unl, sclk, host_oe, sdata_out, sdata_oe, got_v;
    logic out0_en, sp_act, ra, off66, fl_l;
    logic [2:0] prof;
    logic [4:0] code;
    logic [3:0] fsel;
    logic [7:0] lb, sp, got;
    logic [3:0] cfs;
    logic [7:0] q[$];
    wire sdata = !host_oe && !(sdata_oe && !sdata_out);
    int error_cnt = 0;
    int cmp_count = 0;

    always #50 clk = !clk;

    cgr_host_model host (.clk(clk), .sclk(sclk), .host_oe(host_oe),
        .sdata(sdata), .got(got), .got_v(got_v), .nack_cnt());
    cgr_regs uut (.clk(clk), .rst(rst), .sclk(sclk), .sdata_in(sdata),
        .sdata_out(sdata_out), .sdata_oe(sdata_oe),
        .floppy_clock_select_pin(fl), .freq_select_pin(fs),
        .aligner_mode(am), .bus_link_clock_out0_enable(out0_en),
        .spread_active(sp_act), .spread_profile(prof),
        .link_clock_rate_aligner(ra), .link_clock_rate_code(code),
        .link_clock_66_off(off66), .floppy_clock_select_latch(fl_l),
        .freq_select(fsel));

    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        cmp_count++;
        if (g !== e) begin
            error_cnt++;
            $display("unexpected at %0t: got %h exp %h", $time, g, e);
        end
    endtask

    task automatic tally_and_finish();
        $display("compares %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // Reference model updated as writes are issued
    task automatic wr(input logic [7:0] c, input logic [7:0] d[$]);
        logic nu;
        nu = unl;
        foreach (d[i]) begin
            if (c + i == 0) begin
                nu = d[i][0];
            end else if (unl && c + i == 4) begin
                lb = {d[i][7], lb[6], d[i][5:4], lb[3:0]};
            end else if (unl && c + i == 5) begin
                sp = d[i];
            end
        end
        host.wr_block(c, d);
        unl = nu;
    endtask

    // Expected read bytes noted before the read goes out
    task automatic rd(input logic [7:0] c, input int n);
        q.push_back(RD_COUNT);
        for (int i = 0; i < n; i++) begin
            q.push_back(c + i == 0 ? {7'h00, unl} : c + i == 4 ? lb :
                        c + i == 5 ? sp : 8'h00);
        end
        host.rd_block(c, n);
    endtask

    task automatic outs();
        // Sample away from the launching edge
        @(negedge clk);
        chk({7'h0, out0_en}, {7'h0, lb[7]});
        chk({7'h0, sp_act}, {7'h0, lb[4] & !am});
        chk({5'h0, prof}, {5'h0, sp[7:5]});
        chk({7'h0, ra}, {7'h0, am});
        chk({3'h0, code}, am ? {3'h0, sp[4:0]} : {4'h0, cfs});
        chk({7'h0, off66}, {7'h0, am && sp[4:0] == 5'h00});
        chk({3'h0, fl_l, fsel}, {3'h0, cfl, cfs});
        @(posedge clk);
    endtask

    // Read results compared against the oldest note
    always @(posedge clk) begin
        if (got_v === 1'b1) begin
            if (q.size() == 0) begin
                chk(got, 8'hxx);
            end else begin
                chk(got, q.pop_front());
            end
        end
    end

    // Hang guard
    initial begin
        repeat (100000) @(posedge clk);
        error_cnt++;
        $display("unexpected timeout at %0t", $time);
        tally_and_finish();
    end

    // ************************************************************
    // Main sequence
    // ************************************************************
    initial begin
        logic [31:0] r;
        logic [7:0] d;
        r = $urandom(57);
        fs = r[3:0];
        fl = r[4];
        cfs = r[3:0];
        cfl = r[4];
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        repeat (3) @(posedge clk);
        fs <= ~cfs;
        fl <= !cfl;
        lb = {1'b1, cfl, 1'b0, 1'b1, cfs};
        sp = 8'h60;
        unl = 1'b0;
        outs();
        rd(8'h04, 2);
        $display("test reset done");
        // Locked block: unlock lands only at the next block
        wr(8'h00, {8'h01, 8'h00, 8'h00, 8'h00, 8'h00, 8'hff});
        rd(8'h00, 6);
        outs();
        $display("test unlock done");
        for (int p = 0; p < 8; p++) begin
            r = $urandom;
            am <= p[0];
            d = {p[2:0], p == 3 ? 5'h00 : r[4:0]};
            wr(8'h04, {{p[0], !cfl, 1'b0, p[1], ~cfs}, d});
            outs();
            rd(8'h04, 2);
        end
        $display("test profiles done");
        // Relock in one block: spread byte still taken
        wr(8'h00, {8'h00, 8'h00, 8'h00, 8'h00, 8'h90, 8'h21});
        wr(8'h04, {8'h00, 8'hc7});
        rd(8'h04, 2);
        outs();
        $display("test relock done");
        chk(8'(host.nack_cnt), 8'h00);
        chk(8'(q.size()), 8'h00);
        tally_and_finish();
    end
endmodule
